//--- hdl/smpc_pkg.sv
// constants and types shared by the stop mode power controller
`default_nettype none
package smpc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] SAMP_OFS = 12'h008;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int STOPEN_B = 0;   // stop_instruction_enable
  localparam int PPDS_B   = 1;   // partial_powerdown_select
  localparam int DBGEN_B  = 2;   // debug_entry_enable
  localparam int LOWVOLT_DETECT_ENABLE_B   = 3;   // lowvolt_detect_enable
  localparam int LVSE_B   = 4;   // lowvolt_stop_enable
  localparam int OSCK_B   = 5;   // osc_stop_keepalive
  localparam int ADCK_B   = 6;   // converter async clock enable
  localparam int LVRST_B  = 7;   // 1 reset, 0 interrupt
  localparam int RATE_LSB = 8;   // periodic_wake_rate_select
  localparam int RATE_W   = 3;
  localparam int CTRL_W   = 11;
  // ---------------------------------------------------------------
  // sampled-at-stop fields (sample register)
  // ---------------------------------------------------------------
  localparam int S_DBG_B  = 0;
  localparam int S_LV_B   = 1;
  localparam int S_OSC_B  = 2;
  localparam int S_ADC_B  = 3;
  localparam int S_RTI_B  = 4;
  localparam int S_W      = 5;
  localparam logic [S_W-1:0] SAMP_RST = 5'h00;
  // ---------------------------------------------------------------
  // debug command kinds
  // ---------------------------------------------------------------
  localparam logic [1:0] CMD_MEM  = 2'h0;  // plain memory access
  localparam logic [1:0] CMD_MEMS = 2'h1;  // memory access with status
  localparam logic [1:0] CMD_BGND = 2'h2;  // background request
  localparam logic [1:0] CMD_ACT  = 2'h3;  // active-only (go)
  localparam int SYNC_STAGES = 2;
  // ---------------------------------------------------------------
  // states and power codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN, ST_STOP2, ST_STOP3, ST_BGND
  } smpc_state_e;
  typedef enum logic [1:0] {
    PWR_OFF, PWR_STBY, PWR_ON
  } smpc_pwr_e;
endpackage
`default_nettype wire

//--- hdl/smpc_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module smpc_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // smpc_sync
`default_nettype wire

//--- hdl/smpc_ctrl.sv
// stop mode power controller with apb register access
// Contract
// R01 - background entry from run only when debug entry enabled
// R02 - debug clocks keep running in stop when debug entry enabled
// R03 - regulator stays in full regulation in stop with debug enabled
// R04 - deep stop request with debug enabled enters shallow stop
// R05 - status memory commands in stop return stopped error, no access
// R06 - background command in stop wakes to background if enabled
// R07 - most commands refused in stop, all accepted in background
// R08 - debug stop: core standby, clockgen and regulator active
// R09 - low voltage raises interrupt or reset as configured
// R10 - low-voltage detect plus stop enable keeps regulator active
// R11 - deep stop request with low-voltage stop enters shallow stop
// R12 - low-voltage stop: clockgen off, regulator active, pins held
// R13 - peripheral clocks halt in every stop mode
// R14 - deep stop switches domains off, shallow holds them standby
// R15 - converter runs in shallow stop only with async clock and lvd
// R16 - clockgen runs in shallow stop only with keepalive bit; here it also runs in shallow stop when debug entry was enabled
// R17 - wake timer runs in stop only if rate select was nonzero
// R18 - powerdown select one gives deep stop, zero shallow stop
// R19 - stop while disabled forces illegal opcode reset, no stop
// R20 - settings sampled at stop execution choose the mode
//
// Chosen here: the register addresses and register access over APB.
`default_nettype none
module smpc_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_exec,
  input  wire logic        wake_pin,
  input  wire logic        lvd_below_pin,
  input  wire logic        dbg_cmd_valid,
  input  wire logic [1:0]  dbg_cmd_kind,
  output logic             dbg_cmd_ok,
  output logic             dbg_cmd_err,
  output logic             illegal_op_reset,
  output logic             lvd_irq,
  output logic             lvd_reset,
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             debug_clk_en,
  output logic [1:0]       core_pwr,
  output logic [1:0]       ram_pwr,
  output logic [1:0]       clkgen_pwr,
  output logic [1:0]       adc_pwr,
  output logic [1:0]       reg_pwr,
  output logic             rti_on,
  output logic             pins_held
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  smpc_pkg::smpc_state_e     state, next_state;
  logic [smpc_pkg::CTRL_W-1:0] ctrl;
  logic [smpc_pkg::S_W-1:0]    samp, next_samp;
  logic [1:0] pin_s;
  logic       lvd_q;

  smpc_sync #(
    .W (smpc_pkg::SYNC_STAGES)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({lvd_below_pin, wake_pin}),
    .q       (pin_s)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wake_s  = pin_s[0];
  wire lvd_s   = pin_s[1];
  wire stop_en = ctrl[smpc_pkg::STOPEN_B];
  wire dbg_en  = ctrl[smpc_pkg::DBGEN_B];
  wire lowvolt_detect_enable    = ctrl[smpc_pkg::LOWVOLT_DETECT_ENABLE_B];
  wire lv_stop = lowvolt_detect_enable & ctrl[smpc_pkg::LVSE_B];
  wire [smpc_pkg::RATE_W-1:0] rate =
    ctrl[smpc_pkg::RATE_LSB +: smpc_pkg::RATE_W];
  wire stopped = (state == smpc_pkg::ST_STOP2) |
                 (state == smpc_pkg::ST_STOP3);
  wire in_run  = (state == smpc_pkg::ST_RUN);
  wire in_bgnd = (state == smpc_pkg::ST_BGND);
  wire stop_ok = in_run & stop_exec & stop_en;
  wire stop_bad = in_run & stop_exec & ~stop_en;   // R19
  // deep stop only when selected and not overridden
  wire go_deep = ctrl[smpc_pkg::PPDS_B] & ~dbg_en
                 & ~lv_stop;                      // R04 R11 R18
  wire s_dbg = samp[smpc_pkg::S_DBG_B];
  wire s_lv  = samp[smpc_pkg::S_LV_B];
  wire is_bg = dbg_cmd_valid &
               (dbg_cmd_kind == smpc_pkg::CMD_BGND);
  wire is_go = dbg_cmd_valid &
               (dbg_cmd_kind == smpc_pkg::CMD_ACT);

  // command acceptance per mode
  function automatic logic cmd_ok_f(
    input logic [1:0] k, input logic run, input logic bg,
    input logic st, input logic de, input logic sde);
    logic r;
    r = 1'b0;
    if (bg)
      r = 1'b1;                                   // R07
    else if (run)
      r = (k == smpc_pkg::CMD_BGND) ? de          // R01
        : (k != smpc_pkg::CMD_ACT);
    else if (st)
      r = (k == smpc_pkg::CMD_BGND) & sde;        // R06 R07
    return r;
  endfunction

  wire cmd_ok = dbg_cmd_valid & cmd_ok_f(dbg_cmd_kind,
    in_run, in_bgnd, stopped, dbg_en, s_dbg);
  wire cmd_err = dbg_cmd_valid & ~cmd_ok;

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_samp  = samp;
    case (state)
      smpc_pkg::ST_RUN: begin
        if (stop_ok) begin
          next_state = go_deep ? smpc_pkg::ST_STOP2
                               : smpc_pkg::ST_STOP3;
          next_samp = {(rate != '0), ctrl[smpc_pkg::ADCK_B] & lowvolt_detect_enable,
                       ctrl[smpc_pkg::OSCK_B], lv_stop,
                       dbg_en};                  // R20 R17
        end else if (is_bg && dbg_en) begin
          next_state = smpc_pkg::ST_BGND;        // R01
        end
      end
      smpc_pkg::ST_STOP2, smpc_pkg::ST_STOP3: begin
        if (is_bg && s_dbg)
          next_state = smpc_pkg::ST_BGND;        // R06
        else if (wake_s)
          next_state = smpc_pkg::ST_RUN;
      end
      smpc_pkg::ST_BGND: begin
        if (is_go)
          next_state = smpc_pkg::ST_RUN;
      end
      default: next_state = smpc_pkg::ST_RUN;
    endcase
  end

  // state and sampled settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= smpc_pkg::ST_RUN;
      samp  <= smpc_pkg::SAMP_RST;
    end else if (ce) begin
      state <= next_state;
      samp  <= next_samp;
    end
  end

  // event pulses and command answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_op_reset <= 1'b0;
      dbg_cmd_ok       <= 1'b0;
      dbg_cmd_err      <= 1'b0;
      lvd_irq          <= 1'b0;
      lvd_reset        <= 1'b0;
      lvd_q            <= 1'b0;
    end else if (ce) begin
      illegal_op_reset <= stop_bad;               // R19
      dbg_cmd_ok       <= cmd_ok;
      dbg_cmd_err      <= cmd_err;                // R05 R07
      lvd_q            <= lvd_s;
      lvd_irq   <= lowvolt_detect_enable & lvd_s & ~lvd_q &
                   ~ctrl[smpc_pkg::LVRST_B];      // R09
      lvd_reset <= lowvolt_detect_enable & lvd_s & ~lvd_q &
                   ctrl[smpc_pkg::LVRST_B];       // R09
    end
  end

  // ---------------------------------------------------------------
  // power and clock outputs, decoded from registered state
  // ---------------------------------------------------------------
  wire deep = (state == smpc_pkg::ST_STOP2);
  assign core_clk_en   = in_run | in_bgnd;
  assign periph_clk_en = in_run | in_bgnd;        // R13
  assign debug_clk_en  = ~stopped | s_dbg;        // R02
  assign pins_held     = stopped;                 // R14
  assign rti_on = stopped & samp[smpc_pkg::S_RTI_B];  // R17
  assign ram_pwr = stopped ? smpc_pkg::PWR_STBY
                           : smpc_pkg::PWR_ON;    // R14
  assign core_pwr = !stopped ? smpc_pkg::PWR_ON
                  : deep ? smpc_pkg::PWR_OFF
                  : smpc_pkg::PWR_STBY;           // R08 R12 R14
  assign reg_pwr = (!stopped || s_dbg || s_lv)
                 ? smpc_pkg::PWR_ON
                 : smpc_pkg::PWR_STBY;            // R03 R10
  assign adc_pwr = !stopped ? smpc_pkg::PWR_ON
                 : deep ? smpc_pkg::PWR_OFF
                 : samp[smpc_pkg::S_ADC_B] ? smpc_pkg::PWR_ON
                 : smpc_pkg::PWR_STBY;            // R15
  assign clkgen_pwr = !stopped ? smpc_pkg::PWR_ON
                    : deep ? smpc_pkg::PWR_OFF
                    : (s_dbg | samp[smpc_pkg::S_OSC_B])
                      ? smpc_pkg::PWR_ON          // R08 R16
                    : s_lv ? smpc_pkg::PWR_OFF    // R12
                    : smpc_pkg::PWR_STBY;

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  wire hit_ctrl = (paddr == smpc_pkg::CTRL_OFS);
  wire hit_stat = (paddr == smpc_pkg::STAT_OFS);
  wire hit_samp = (paddr == smpc_pkg::SAMP_OFS);
  wire hit      = hit_ctrl | hit_stat | hit_samp;
  wire setup    = psel & ~penable;
  wire wr_ctrl  = psel & penable & pwrite & hit_ctrl;
  wire [31:0] rd_mux =
      hit_ctrl ? {21'h00_0000, ctrl}
    : hit_stat ? {30'h0000_0000, state}
    : hit_samp ? {27'h000_0000, samp}
    : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // control write in the access phase, read capture in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= smpc_pkg::CTRL_RST[smpc_pkg::CTRL_W-1:0];
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl <= pwdata[smpc_pkg::CTRL_W-1:0];
      if (setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_taken;
    ce && stop_ok;
  endsequence
  sequence s_forced_shallow;
    s_stop_taken ##0 (dbg_en || lv_stop);
  endsequence

  a_no_deep_dbg: assert property (s_forced_shallow |=>  // R04
    state == smpc_pkg::ST_STOP3)
    else $error("deep stop entered despite override");
  a_deep_select: assert property (s_stop_taken ##0 // R18
    ctrl[smpc_pkg::PPDS_B] && !dbg_en && !lv_stop |=>
    state == smpc_pkg::ST_STOP2 && core_pwr == smpc_pkg::PWR_OFF)
    else $error("deep stop not entered");
  a_illegal_stop: assert property (ce && stop_bad |=>   // R19
    illegal_op_reset && state == smpc_pkg::ST_RUN)
    else $error("disabled stop not trapped");
  a_periph_gate: assert property (stopped |->           // R13
    !periph_clk_en && !core_clk_en)
    else $error("peripheral clock running in stop");
  a_dbg_keep: assert property (stopped && s_dbg |->     // R02
    debug_clk_en && reg_pwr == smpc_pkg::PWR_ON &&
    clkgen_pwr == smpc_pkg::PWR_ON)
    else $error("debug stop lost clock or regulator");
  a_memst_err: assert property (ce && stopped &&        // R05
    dbg_cmd_valid && dbg_cmd_kind == smpc_pkg::CMD_MEMS |=>
    dbg_cmd_err && !dbg_cmd_ok)
    else $error("status command not refused in stop");
  a_bg_wake: assert property (ce && stopped && is_bg && // R06
    s_dbg |=> in_bgnd ##1 !stopped)
    else $error("background command did not wake");
  a_bgnd_all: assert property (ce && in_bgnd &&         // R07
    dbg_cmd_valid |=> dbg_cmd_ok)
    else $error("command refused in background");
  a_run_gate: assert property (ce && in_run && is_bg && // R01
    !dbg_en && !stop_exec |=> in_run && dbg_cmd_err)
    else $error("background entered while disabled");
  a_rti_keep: assert property (s_stop_taken |=>         // R17
    rti_on == ($past(rate) != 3'h0))
    else $error("wake timer state wrong");
  a_lv_reg: assert property (s_stop_taken ##0 lv_stop   // R10
    |=> reg_pwr == smpc_pkg::PWR_ON)
    else $error("regulator dropped with lvd stop");
  a_lvd_event: assert property (ce && lowvolt_detect_enable && lvd_s &&  // R09
    !lvd_q |=> lvd_irq != lvd_reset)
    else $error("low voltage event not raised");
  // clock enable low must freeze mode and control state
  a_ce_freeze: assert property (!ce |=>
    $stable(state) && $stable(ctrl) && $stable(samp))
    else $error("state moved while clock enable low");
endmodule // smpc_ctrl
`default_nettype wire

//--- testbench/smpc_core_model.sv
// core and debug host model that drives the controller's far side
`default_nettype none
module smpc_core_model (
  input  wire logic       pclk,
  output logic            stop_exec,
  output logic            dbg_cmd_valid,
  output logic [1:0]      dbg_cmd_kind,
  output logic            wake_pin,
  output logic            lvd_below_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  initial begin
    stop_exec = 1'b0;
    dbg_cmd_valid = 1'b0;
    dbg_cmd_kind = 2'h0;
    wake_pin = 1'b0;
    lvd_below_pin = 1'b0;
  end
  // one-cycle stop strobe from the core
  task automatic stop_now();
    @(posedge pclk);
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
  endtask
  // command strobe; the kind lines scramble once released
  task automatic dbg_cmd(input logic [1:0] k);
    @(posedge pclk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd_kind <= k;
    @(posedge pclk);
    dbg_cmd_valid <= 1'b0;
    dbg_cmd_kind <= ~k;
  endtask
  // level held long enough to cross the synchroniser
  task automatic pin_pulse(input bit low_voltage_detector);
    @(posedge pclk);
    if (low_voltage_detector) lvd_below_pin <= 1'b1;
    else wake_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    lvd_below_pin <= 1'b0;
    wake_pin <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule // smpc_core_model
`default_nettype wire

//--- testbench/smpc_ctrl_tb.sv
// self-checking bench for the stop mode power controller
`default_nettype none
module smpc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic        stop_exec, wake_pin, lvd_below_pin, dbg_cmd_valid;
  logic [1:0]  dbg_cmd_kind, core_pwr, ram_pwr, clkgen_pwr, adc_pwr, reg_pwr;
  logic        dbg_cmd_ok, dbg_cmd_err, illegal_op_reset, lvd_irq, lvd_reset;
  logic        core_clk_en, periph_clk_en, debug_clk_en, rti_on, pins_held;
  logic        er;
  logic [10:0] c;
  logic [1:0]  k;
  int          n_errors, check_count, cyc;
  int          pc [5];
  int          s [5];
  wire logic [14:0] outs;
  logic [10:0] corner [7] = '{11'h003, 11'h007, 11'h01b, 11'h001,
                              11'h000, 11'h579, 11'h70d};
  assign outs = {core_pwr, ram_pwr, clkgen_pwr, adc_pwr, reg_pwr, rti_on,
                 pins_held, core_clk_en, periph_clk_en, debug_clk_en};
  smpc_ctrl i_smpc_ctrl (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_exec, .wake_pin,
    .lvd_below_pin, .dbg_cmd_valid, .dbg_cmd_kind, .dbg_cmd_ok,
    .dbg_cmd_err, .illegal_op_reset, .lvd_irq, .lvd_reset, .core_clk_en,
    .periph_clk_en, .debug_clk_en, .core_pwr, .ram_pwr, .clkgen_pwr,
    .adc_pwr, .reg_pwr, .rti_on, .pins_held);
  smpc_core_model i_smpc_core_model (.pclk, .stop_exec, .dbg_cmd_valid,
    .dbg_cmd_kind, .wake_pin, .lvd_below_pin);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction
  // expected power, clock and pin outputs in run or stop
  function automatic logic [14:0] exp_out(input logic [10:0] v, bit stp);
    logic dbg, lv, deep;
    logic [1:0] cg;
    dbg = v[2];
    lv = v[3] & v[4];
    deep = v[1] & !dbg & !lv;
    cg = deep ? 2'h0 : (dbg | v[5]) ? 2'h2 : lv ? 2'h0 : 2'h1;
    if (!stp) return {10'h2aa, 2'b00, 3'h7};
    return {deep ? 2'h0 : 2'h1, 2'h1, cg,
            deep ? 2'h0 : (v[6] & v[3]) ? 2'h2 : 2'h1,
            (dbg | lv) ? 2'h2 : 2'h1, |v[10:8], 1'b1, 2'b00, dbg};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // apb master: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, pulse counters, timeout
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    pc[0] += (dbg_cmd_ok === 1'b1);
    pc[1] += (dbg_cmd_err === 1'b1);
    pc[2] += (illegal_op_reset === 1'b1);
    pc[3] += (lvd_irq === 1'b1);
    pc[4] += (lvd_reset === 1'b1);
    if (cyc > 40000) begin
      n_errors++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    seed = 32'hd5e3_f961;
    pc = '{default: 0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk("outs_rst", exp_out(11'h000, 0), outs);
    // a write with the clock enable low must not land
    ce <= 1'b0;
    apb(1'b1, smpc_pkg::CTRL_OFS, 32'h0000_07ff);
    ce <= 1'b1;
    apb(1'b1, smpc_pkg::STAT_OFS, 32'h0000_0003);
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, a[11:0], 32'h0000_0000);
      chk("rd_rst", 32'h0000_0000, rd);
      chk("slverr", a == 12, er);
    end
    for (int i = 0; i < 200; i++) begin
      seed = lfsr(seed);
      c = (i < 7) ? corner[i]
        : (seed[10:0] | {10'h000, seed[15:14] != 2'b00});
      apb(1'b1, smpc_pkg::CTRL_OFS, {21'h00_0000, c});
      apb(1'b0, smpc_pkg::CTRL_OFS, 32'h0000_0000);
      chk("ctrl", {21'h00_0000, c}, rd);
      // background request then go, from run
      s = pc;
      i_smpc_core_model.dbg_cmd(2'h2);
      i_smpc_core_model.dbg_cmd(2'h3);
      idle(2);
      chk("run_ok", c[2] ? 2 : 0, pc[0] - s[0]);
      chk("run_err", c[2] ? 0 : 2, pc[1] - s[1]);
      i_smpc_core_model.pin_pulse(1'b1);
      chk("lv_irq", c[3] & !c[7], pc[3] - s[3]);
      chk("lv_rst", c[3] & c[7], pc[4] - s[4]);
      i_smpc_core_model.stop_now();
      #1;
      if (!c[0]) begin
        idle(3);
        chk("illegal", 1, pc[2] - s[2]);
        chk("outs_run", exp_out(c, 0), outs);
        continue;
      end
      chk("outs_stop", exp_out(c, 1), outs);
      apb(1'b0, smpc_pkg::STAT_OFS, 32'h0000_0000);
      chk("stat", (c[1] & !c[2] & !(c[3] & c[4])) ? 1 : 2, rd);
      apb(1'b0, smpc_pkg::SAMP_OFS, 32'h0000_0000);
      chk("samp", {|c[10:8], c[6] & c[3], c[5], c[4] & c[3], c[2]}, rd);
      apb(1'b1, smpc_pkg::CTRL_OFS, ~seed);
      #1 chk("outs_held", exp_out(c, 1), outs);
      k = (i < 7) ? 2'h2 : seed[17:16];
      s = pc;
      i_smpc_core_model.dbg_cmd(k);
      idle(2);
      chk("stop_ok", k == 2 && c[2], pc[0] - s[0]);
      chk("stop_err", !(k == 2 && c[2]), pc[1] - s[1]);
      if (k == 2 && c[2]) begin
        apb(1'b0, smpc_pkg::STAT_OFS, 32'h0000_0000);
        chk("stat_bg", 3, rd);
        for (int j = 0; j < 4; j++) i_smpc_core_model.dbg_cmd(j[1:0]);
        idle(2);
        chk("bg_ok", 5, pc[0] - s[0]);
      end else begin
        i_smpc_core_model.pin_pulse(1'b0);
      end
      #1 chk("outs_back", exp_out(c, 0), outs);
    end
    // mid-run reset out of a debug stop
    apb(1'b1, smpc_pkg::CTRL_OFS, 32'h0000_0005);
    i_smpc_core_model.stop_now();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk("outs_rst2", exp_out(11'h000, 0), outs);
    apb(1'b0, smpc_pkg::SAMP_OFS, 32'h0000_0000);
    chk("samp_rst", 32'h0000_0000, rd);
    apb(1'b0, smpc_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl_rst", 32'h0000_0000, rd);
    complete_run();
  end
endmodule // smpc_ctrl_tb
`default_nettype wire
